/* hdl/sfr_map_pkg.sv */
// Package with offsets, reset values and the cell table of the special register map.
package sfr_map_pkg;

  // ---------------------------------------------------------------------------
  // Bus and index layout.
  // ---------------------------------------------------------------------------
  localparam int         ADDR_W = 12;
  localparam int         IDX_W  = 10;
  localparam logic [9:0] IDX_BANK1_BASE   = 10'h080;
  localparam logic [9:0] IDX_ALIAS_LAST   = 10'h004;
  localparam logic [9:0] IDX_ALIAS_HOLE   = 10'h001;
  localparam logic [9:0] IDX_UART_RX      = 10'h01A;
  localparam logic [9:0] IDX_CONV_HIGH    = 10'h01E;
  localparam logic [9:0] IDX_SLAVE_ADDR   = 10'h093;
  localparam logic [9:0] IDX_PORT_A       = 10'h102;
  localparam logic [9:0] IDX_PORT_B       = 10'h103;
  localparam logic [9:0] IDX_CHANGE_FLAG  = 10'h104;
  localparam logic [9:0] IDX_INT_STATUS   = 10'h105;

  // ---------------------------------------------------------------------------
  // Fields and reset values.
  // ---------------------------------------------------------------------------
  localparam logic [3:0] MODE_MASK_ACCESS = 4'h9;
  localparam int         MODE_LSB         = 0;
  localparam int         CHANGE_FLAG_BIT  = 0;
  localparam int         INT_W            = 2;
  localparam int         INT_PORT_CHANGE  = 0;
  localparam int         INT_WARM_RESET   = 1;
  localparam logic [7:0] ZERO_BYTE        = 8'h00;
  localparam logic [1:0] INT_STATUS_RESET = 2'h0;

  // ---------------------------------------------------------------------------
  // Storage cell table.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] por_val;
    logic [7:0] warm_val;
    logic [7:0] keep_mask;
    logic [7:0] wr_mask;
    logic [7:0] rd_mask;
  } cell_s;

  localparam int NUM_CELLS = 30;
  localparam int CELL_TIMER1_CONTROL = 0;
  localparam int CELL_SERIAL_CONTROL = 4;
  localparam int CELL_UART_TX        = 9;
  localparam int CELL_OPTION         = 14;
  localparam int CELL_PC_LOW         = 15;
  localparam int CELL_POINTER        = 17;
  localparam int CELL_DIR_A          = 18;
  localparam int CELL_DIR_B          = 19;
  localparam int CELL_SLAVE_ADDR     = 23;
  localparam int CELL_ADDR_MASK      = 24;
  localparam int CELL_ANALOG_LOW     = 25;
  localparam int CELL_ANALOG_HIGH    = 26;
  localparam int CELL_PORT_A         = 27;
  localparam int CELL_PORT_B         = 28;
  localparam int CELL_INT_MASK       = 29;

  //                                 idx      por    warm   keep   wr     rd
  localparam cell_s CELL_MAP [NUM_CELLS] = '{
    '{10'h010, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF},  // Timer1 control, kept on warm reset.
    '{10'h011, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF},  // Timer2 count.
    '{10'h012, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h7F},  // Timer2 control.
    '{10'h013, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF},  // Serial port buffer.
    '{10'h014, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF},  // Serial port control.
    '{10'h015, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF},  // Capture/compare 1 low.
    '{10'h016, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF},  // Capture/compare 1 high.
    '{10'h017, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF},  // Capture/compare 1 control.
    '{10'h018, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF},  // Receiver status and control.
    '{10'h019, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00},  // Transmit data, write only.
    '{10'h01B, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF},  // Capture/compare 2 low.
    '{10'h01C, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF},  // Capture/compare 2 high.
    '{10'h01D, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F},  // Capture/compare 2 control.
    '{10'h01F, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF},  // Converter control 0.
    '{10'h081, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF},  // Option settings.
    '{10'h082, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF},  // Program counter low, cleared by all resets.
    '{10'h083, 8'h18, 8'h00, 8'h1F, 8'hE7, 8'hFF},  // CPU flags.
    '{10'h084, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF},  // Indirect pointer.
    '{10'h085, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF},  // Port A direction.
    '{10'h086, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF},  // Port B direction.
    '{10'h087, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF},  // Port C direction.
    '{10'h088, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF},  // Port D direction.
    '{10'h089, 8'h0F, 8'h0F, 8'h00, 8'h0F, 8'h0F},  // Port E direction.
    '{10'h093, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF},  // Serial slave address.
    '{10'h093, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF},  // Serial address mask.
    '{10'h100, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF},  // Analog select low, all analog after reset.
    '{10'h101, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF},  // Analog select high, all analog after reset.
    '{10'h102, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00},  // Port A latch, kept on warm reset.
    '{10'h103, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00},  // Port B latch, kept on warm reset.
    '{10'h106, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03}   // Interrupt mask.
  };

endpackage : sfr_map_pkg

/* hdl/special_register_map_slice.sv */
// Special register map slice with its APB slave, reset handling and port change logic.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none

// -----------------------------------------------------------------------------
// Storage cell with power, brown-out and warm reset behaviour.
// -----------------------------------------------------------------------------
module sfr_cell #(
  parameter logic [7:0] POR_VAL   = 8'h00,
  parameter logic [7:0] WARM_VAL  = 8'h00,
  parameter logic [7:0] KEEP_MASK = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       por_sync,
  input  wire logic       warm_rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  logic [7:0] value_ff;
  logic [7:0] nxt_value;

  assign nxt_value = por_sync ? POR_VAL :
                     warm_rst ? ((value_ff & KEEP_MASK) | (WARM_VAL & ~KEEP_MASK)) :
                     wr_en    ? ((value_ff & ~WR_MASK) | (wdata & WR_MASK)) :
                                value_ff;
  assign q = value_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= POR_VAL;
    end else begin
      value_ff <= nxt_value;
    end
  end

endmodule : sfr_cell

// -----------------------------------------------------------------------------
// Top of the register map.
// -----------------------------------------------------------------------------
module special_register_map_slice (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [sfr_map_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  input  wire logic                             brown_out_reset,
  input  wire logic                             external_clear_reset,
  input  wire logic                             watchdog_timeout_reset,
  input  wire logic [7:0]                       pin_a,
  input  wire logic [7:0]                       pin_b,
  input  wire logic [7:0]                       uart_rx_data,
  input  wire logic [7:0]                       converter_result,
  output logic      [7:0]                       port_a_out,
  output logic      [7:0]                       port_b_out,
  output logic      [7:0]                       port_a_dir,
  output logic      [7:0]                       port_b_dir,
  output logic      [7:0]                       timer1_control,
  output logic      [7:0]                       uart_tx_data,
  output logic      [7:0]                       option_settings,
  output logic      [7:0]                       program_counter_low,
  output logic      [7:0]                       indirect_pointer,
  output logic      [7:0]                       serial_slave_address_reg,
  output logic      [7:0]                       serial_address_mask_reg,
  output logic                                  port_b_change_flag,
  output logic                                  irq
);
  import sfr_map_pkg::*;

  // ---------------------------------------------------------------------------
  // Address decode.
  // ---------------------------------------------------------------------------
  function automatic logic idx_hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] b);
    idx_hit = (a == b);
  endfunction : idx_hit

  logic             pready_ff;
  logic [7:0]       prdata_ff;
  logic [7:0]       snapshot_ff;
  logic             change_ff;
  logic [INT_W-1:0] int_status_ff;
  logic             irq_ff;
  logic [7:0]       cell_q [NUM_CELLS];
  logic [7:0]       rd_term [NUM_CELLS];
  logic [7:0]       rd_cells;

  wire logic [IDX_W-1:0] raw_idx    = paddr[ADDR_W-1:2];
  wire logic             alias_low  = (raw_idx <= IDX_ALIAS_LAST) && (raw_idx != IDX_ALIAS_HOLE);
  wire logic [IDX_W-1:0] eff_idx    = alias_low ? (raw_idx | IDX_BANK1_BASE) : raw_idx;
  wire logic             access_ph  = psel & penable;
  wire logic             taken      = access_ph & pready_ff;
  wire logic             wr_taken   = taken & pwrite;
  wire logic             rd_taken   = taken & ~pwrite;
  wire logic [7:0]       wbyte      = pwdata[7:0];
  wire logic             warm_rst   = external_clear_reset | watchdog_timeout_reset;
  wire logic             any_sync   = brown_out_reset | warm_rst;
  wire logic [3:0]       port_mode  = cell_q[CELL_SERIAL_CONTROL][MODE_LSB+3:MODE_LSB];
  wire logic             mask_mode  = (port_mode == MODE_MASK_ACCESS);

  wire logic sel_rx      = idx_hit(eff_idx, IDX_UART_RX);
  wire logic sel_conv    = idx_hit(eff_idx, IDX_CONV_HIGH);
  wire logic sel_port_a  = idx_hit(eff_idx, IDX_PORT_A);
  wire logic sel_port_b  = idx_hit(eff_idx, IDX_PORT_B);
  wire logic sel_change  = idx_hit(eff_idx, IDX_CHANGE_FLAG);
  wire logic sel_status  = idx_hit(eff_idx, IDX_INT_STATUS);

  // ---------------------------------------------------------------------------
  // Storage cells.
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CELLS; g++) begin : gen_cell
      logic gate;
      logic hit;
      if (g == CELL_SLAVE_ADDR) begin : gen_addr
        assign gate = ~mask_mode;
      end else if (g == CELL_ADDR_MASK) begin : gen_mask
        assign gate = mask_mode;
      end else begin : gen_plain
        assign gate = 1'b1;
      end
      assign hit        = gate & idx_hit(eff_idx, CELL_MAP[g].idx);
      assign rd_term[g] = hit ? (cell_q[g] & CELL_MAP[g].rd_mask) : ZERO_BYTE;
      sfr_cell #(
        .POR_VAL   (CELL_MAP[g].por_val),
        .WARM_VAL  (CELL_MAP[g].warm_val),
        .KEEP_MASK (CELL_MAP[g].keep_mask),
        .WR_MASK   (CELL_MAP[g].wr_mask)
      ) u_cell (
        .pclk     (pclk),
        .presetn  (presetn),
        .por_sync (brown_out_reset),
        .warm_rst (warm_rst),
        .wr_en    (wr_taken & hit),
        .wdata    (wbyte),
        .q        (cell_q[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Read data selection.
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_cells = ZERO_BYTE;
    for (int i = 0; i < NUM_CELLS; i++) begin
      rd_cells = rd_cells | rd_term[i];
    end
  end

  wire logic [7:0] pin_a_read = pin_a & ~cell_q[CELL_ANALOG_LOW];
  wire logic [7:0] pin_b_read = pin_b & ~cell_q[CELL_ANALOG_HIGH];
  wire logic [7:0] rd_value   = rd_cells
                              | ({8{sel_rx}}     & uart_rx_data)
                              | ({8{sel_conv}}   & converter_result)
                              | ({8{sel_port_a}} & pin_a_read)
                              | ({8{sel_port_b}} & pin_b_read)
                              | ({8{sel_change}} & {7'h00, change_ff})
                              | ({8{sel_status}} & {6'h00, int_status_ff});

  // ---------------------------------------------------------------------------
  // Port B change flag and interrupt status.
  // ---------------------------------------------------------------------------
  wire logic       mismatch     = (pin_b_read != snapshot_ff);
  wire logic       change_clear = wr_taken & sel_change & ~wbyte[CHANGE_FLAG_BIT];
  wire logic       nxt_change   = any_sync ? 1'b0 :
                                  mismatch ? 1'b1 :
                                  change_clear ? 1'b0 : change_ff;
  // Snapshot and read-clear use the byte actually returned, so a change during the wait state is not lost.
  wire logic [7:0] nxt_snapshot = (rd_taken & sel_port_b) ? prdata_ff : snapshot_ff;

  wire logic [INT_W-1:0] int_events;
  assign int_events[INT_PORT_CHANGE] = nxt_change & ~change_ff;
  assign int_events[INT_WARM_RESET]  = warm_rst;

  wire logic             status_rdclr   = rd_taken & sel_status;
  wire logic [INT_W-1:0] int_kept       = status_rdclr ? (int_status_ff & ~prdata_ff[INT_W-1:0]) : int_status_ff;
  wire logic [INT_W-1:0] nxt_int_status = brown_out_reset ? INT_STATUS_RESET : (int_kept | int_events);
  wire logic [INT_W-1:0] int_mask_bits  = cell_q[CELL_INT_MASK][INT_W-1:0];
  wire logic             nxt_irq        = |(nxt_int_status & int_mask_bits);

  // ---------------------------------------------------------------------------
  // APB handshake.
  // ---------------------------------------------------------------------------
  wire logic       nxt_pready = access_ph & ~pready_ff;
  wire logic [7:0] nxt_prdata = (access_ph & ~pready_ff & ~pwrite) ? rd_value : prdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= ZERO_BYTE;
    end else begin
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snapshot_ff   <= ZERO_BYTE;
      change_ff     <= 1'b0;
      int_status_ff <= INT_STATUS_RESET;
      irq_ff        <= 1'b0;
    end else begin
      snapshot_ff   <= nxt_snapshot;
      change_ff     <= nxt_change;
      int_status_ff <= nxt_int_status;
      irq_ff        <= nxt_irq;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  assign prdata                   = {24'h000000, prdata_ff};
  assign pready                   = pready_ff;
  assign port_a_out               = cell_q[CELL_PORT_A];
  assign port_b_out               = cell_q[CELL_PORT_B];
  assign port_a_dir               = cell_q[CELL_DIR_A];
  assign port_b_dir               = cell_q[CELL_DIR_B];
  assign timer1_control           = cell_q[CELL_TIMER1_CONTROL];
  assign uart_tx_data             = cell_q[CELL_UART_TX];
  assign option_settings          = cell_q[CELL_OPTION];
  assign program_counter_low      = cell_q[CELL_PC_LOW];
  assign indirect_pointer         = cell_q[CELL_POINTER];
  assign serial_slave_address_reg = cell_q[CELL_SLAVE_ADDR];
  assign serial_address_mask_reg  = cell_q[CELL_ADDR_MASK];
  assign port_b_change_flag       = change_ff;
  assign irq                      = irq_ff;

endmodule : special_register_map_slice

`default_nettype wire

/* test/cpu_bus_master.sv */
// Bus master model of the CPU core issuing register reads and writes.
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_master (
  input  wire logic                           pclk,
  output logic                                psel,
  output logic                                penable,
  output logic                                pwrite,
  output logic      [sfr_map_pkg::ADDR_W-1:0] paddr,
  output logic      [31:0]                    pwdata,
  input  wire logic [31:0]                    prdata,
  input  wire logic                           pready
);
  import sfr_map_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // Released address and data lines show the inverse of their last value.
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~{24'h0, d};
  endtask : xfer
endmodule : cpu_bus_master
`default_nettype wire

/* test/special_register_map_slice_assertions.sv */
// Checker with the concurrent assertions of the register map slice.
`timescale 1ns/100ps
`default_nettype none
module sfr_map_checker (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [sfr_map_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic [31:0]                    prdata,
  input wire logic                           pready,
  input wire logic                           brown_out_reset,
  input wire logic                           external_clear_reset,
  input wire logic                           watchdog_timeout_reset,
  input wire logic [7:0]                     port_a_out,
  input wire logic [7:0]                     port_b_out,
  input wire logic [7:0]                     timer1_control,
  input wire logic [7:0]                     option_settings,
  input wire logic [7:0]                     program_counter_low,
  input wire logic [7:0]                     serial_slave_address_reg,
  input wire logic [7:0]                     serial_address_mask_reg,
  input wire logic                           port_b_change_flag
);
  import sfr_map_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       any_rst = external_clear_reset | watchdog_timeout_reset | brown_out_reset;
  wire       warm    = (external_clear_reset | watchdog_timeout_reset) & ~brown_out_reset;
  wire       taken   = psel & penable & pready & ~any_rst;
  wire [7:0] wbyte   = pwdata[7:0];
  a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("Upper read bits not zero.");
  a_unmapped_zero: assert property (taken && !pwrite && paddr[11:2] > 10'h106 |-> prdata == 32'h0)
    else $error("Unmapped read not zero.");
  a_mask_one_path: assert property (taken && pwrite && paddr == 12'h24C
    |=> $stable(serial_slave_address_reg) || $stable(serial_address_mask_reg)) else $error("Both address regs hit.");
  a_latch_kept: assert property (warm |=> $stable(port_a_out) && $stable(port_b_out))
    else $error("Port latch lost on warm reset.");
  a_flag_cleared: assert property (any_rst |=> !port_b_change_flag) else $error("Change flag not cleared.");
  a_timer1_kept: assert property (warm |=> $stable(timer1_control)) else $error("Timer1 control lost.");
  a_power_values: assert property (brown_out_reset |=> timer1_control == 8'h00 && option_settings == 8'hFF)
    else $error("Power values not loaded.");
  a_pc_cleared: assert property (any_rst |=> program_counter_low == 8'h00) else $error("PC low not cleared.");
  a_pc_alias: assert property (taken && pwrite && (paddr == 12'h008 || paddr == 12'h208)
    |=> program_counter_low == $past(wbyte)) else $error("PC low alias write lost.");
endmodule : sfr_map_checker
bind special_register_map_slice sfr_map_checker i_sfr_map_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .brown_out_reset, .external_clear_reset, .watchdog_timeout_reset,
  .port_a_out, .port_b_out, .timer1_control, .option_settings, .program_counter_low,
  .serial_slave_address_reg, .serial_address_mask_reg, .port_b_change_flag);
`default_nettype wire

/* test/tb_special_register_map_slice.sv */
// Self-checking testbench of the register map slice.
`timescale 1ns/100ps
`default_nettype none
module tb_special_register_map_slice;
  import sfr_map_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, irq, port_b_change_flag;
  logic brown_out_reset = 1'b0, external_clear_reset = 1'b0, watchdog_timeout_reset = 1'b0;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] pin_a = 8'h0F, pin_b = 8'h00, uart_rx_data = 8'h3C, converter_result = 8'hC5;
  logic [7:0] port_a_out, port_b_out, timer1_control, uart_tx_data, option_settings, program_counter_low;
  logic [7:0] indirect_pointer, serial_slave_address_reg, serial_address_mask_reg, port_a_dir, port_b_dir;
  int failures = 0, checks_done = 0, cycles = 0;
  special_register_map_slice i_special_register_map_slice (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .brown_out_reset, .external_clear_reset, .watchdog_timeout_reset, .pin_a, .pin_b,
    .uart_rx_data, .converter_result, .port_a_out, .port_b_out, .port_a_dir, .port_b_dir, .timer1_control,
    .uart_tx_data, .option_settings, .program_counter_low, .indirect_pointer, .serial_slave_address_reg,
    .serial_address_mask_reg, .port_b_change_flag, .irq);
  cpu_bus_master i_cpu_bus_master (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ---------------------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------------------
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    i_cpu_bus_master.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    i_cpu_bus_master.xfer(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  // Kind 0 is brown-out, 1 external clear, 2 watchdog.
  task automatic pulse(input int k);
    @(posedge pclk);
    brown_out_reset <= (k == 0);
    external_clear_reset <= (k == 1);
    watchdog_timeout_reset <= (k == 2);
    @(posedge pclk);
    brown_out_reset <= 1'b0;
    external_clear_reset <= 1'b0;
    watchdog_timeout_reset <= 1'b0;
    #1;
  endtask : pulse
  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_unimpl();
    logic [ADDR_W-1:0] ua [6] = '{12'h048, 12'h074, 12'h224, 12'hFFC, 12'h200, 12'h064};
    logic [7:0] ue [6] = '{8'h7F, 8'h3F, 8'h0F, 8'h00, 8'h00, 8'h00};
    rd(12'h040, 8'h00);
    rd(12'h20C, 8'h18);
    rd(12'h208, 8'h00);
    foreach (ua[i]) begin
      wr(ua[i], 8'hFF);
      rd(ua[i], ue[i]);
    end
    chk(uart_tx_data, 8'hFF);
    rd(12'h068, 8'h3C);
    rd(12'h078, 8'hC5);
  endtask : t_unimpl
  task automatic t_mask();
    wr(12'h050, 8'h09);
    wr(12'h24C, 8'hA5);
    rd(12'h24C, 8'hA5);
    chk(serial_address_mask_reg, 8'hA5);
    chk(serial_slave_address_reg, 8'h00);
    wr(12'h050, 8'h08);
    wr(12'h24C, 8'h3C);
    rd(12'h24C, 8'h3C);
    chk(serial_address_mask_reg, 8'hA5);
    chk(serial_slave_address_reg, 8'h3C);
  endtask : t_mask
  task automatic t_alias();
    wr(12'h208, 8'h5A);
    rd(12'h008, 8'h5A);
    wr(12'h010, 8'hC3);
    rd(12'h210, 8'hC3);
    pulse(2);
    chk(program_counter_low, 8'h00);
    chk(indirect_pointer, 8'hC3);
  endtask : t_alias
  task automatic t_warm();
    wr(12'h040, 8'hA5);
    wr(12'h06C, 8'h11);
    wr(12'h070, 8'h22);
    wr(12'h408, 8'h3C);
    wr(12'h40C, 8'hC3);
    wr(12'h214, 8'h12);
    wr(12'h218, 8'h34);
    wr(12'h204, 8'h00);
    chk(port_a_dir, 8'h12);
    chk(port_b_dir, 8'h34);
    for (int k = 2; k >= 0; k--) begin
      pulse(k);
      chk(port_b_out, k > 0 ? 8'hC3 : 8'h00);
      chk(port_a_dir, 8'hFF);
      chk(port_b_dir, 8'hFF);
      chk(timer1_control, k > 0 ? 8'hA5 : 8'h00);
      chk(port_a_out, k > 0 ? 8'h3C : 8'h00);
      chk(option_settings, 8'hFF);
      rd(12'h06C, k > 0 ? 8'h11 : 8'h00);
      rd(12'h070, k > 0 ? 8'h22 : 8'h00);
    end
  endtask : t_warm
  task automatic t_flag();
    @(posedge pclk);
    pin_b <= 8'h55;
    wr(12'h404, 8'h00);
    rd(12'h40C, 8'h55);
    wr(12'h410, 8'h00);
    i_cpu_bus_master.xfer(1'b0, 12'h414, 8'h00, q);
    wr(12'h418, 8'h01);
    tick(2);
    chk(port_b_change_flag, 1'b0);
    @(posedge pclk);
    pin_b <= 8'hAA;
    tick(4);
    chk(port_b_change_flag, 1'b1);
    chk(irq, 1'b1);
    wr(12'h418, 8'h00);
    tick(2);
    chk(irq, 1'b0);
    rd(12'h414, 8'h01);
    pulse(1);
    chk(port_b_change_flag, 1'b0);
    tick(2);
    chk(port_b_change_flag, 1'b1);
    rd(12'h40C, 8'h00);
    rd(12'h408, 8'h00);
    rd(12'h414, 8'h03);
  endtask : t_flag
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_unimpl();
    t_mask();
    t_alias();
    t_warm();
    t_flag();
    end_of_test();
  end
endmodule : tb_special_register_map_slice
`default_nettype wire
